// ===== core/setpoint_pkg.sv
// Purpose: shared constants and types for the light setpoint manager
// Assumes: lux values are plain unsigned integers, 16 bits wide
// Notes: offsets are byte addresses on a 32-bit Avalon-MM slave
package setpoint_pkg;
  // ----------------------------------------
  // widths and register map
  // ----------------------------------------
  localparam int LUX_W = 16;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_TARGET = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG_CEIL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG_DARK = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_HYST = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_NUDGE_HI = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_NUDGE_LO = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_BAND = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_CEIL_EFF = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_DARK_EFF = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h34;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_W = 10;
  localparam int CTRL_USER = 0;
  localparam int CTRL_OVERWRITE = 1;
  localparam int CTRL_WRITE_EN = 2;
  localparam int CTRL_NUDGE_EN = 3;
  localparam int CTRL_NUDGE_PERM = 4;
  localparam int CTRL_LEARN_EN = 5;
  localparam int CTRL_POL_LSB = 6;
  localparam int CTRL_POL_MSB = 7;
  localparam int CTRL_REPORT_EN = 8;
  localparam int CTRL_REPORT_ACT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h200;
  localparam int CMD_DOWNLOAD = 0;
  localparam int CMD_BUS_RETURN = 1;
  localparam logic [1:0] POL_ONE = 2'h0;
  localparam logic [1:0] POL_ZERO = 2'h1;
  // ----------------------------------------
  // lux figures and ratios
  // ----------------------------------------
  localparam logic [LUX_W-1:0] LUX_ZERO = 16'h0000;
  localparam logic [LUX_W-1:0] LUX_MIN = 16'h000A;
  localparam logic [LUX_W-1:0] LUX_MAX = 16'h07D0;
  localparam logic [LUX_W-1:0] LUX_SAT = 16'hFFFF;
  localparam logic [LUX_W-1:0] STD_LOW = 16'h0014;
  localparam logic [LUX_W-1:0] STD_STEP = 16'h0032;
  localparam logic [LUX_W-1:0] STD_MAX = 16'h03E8;
  localparam logic [LUX_W-1:0] TARGET_DEF = 16'h0258;
  localparam logic [LUX_W-1:0] CEIL_DEF = 16'h02D0;
  localparam logic [LUX_W-1:0] DARK_DEF = 16'h00C8;
  localparam logic [LUX_W-1:0] HYST_MIN = 16'h000A;
  localparam logic [LUX_W-1:0] HYST_MAX = 16'h0032;
  localparam logic [18:0] CEIL_NUM = 19'h00006;
  localparam logic [18:0] CEIL_DEN = 19'h00005;
  localparam logic [22:0] PCT = 23'h000064;
  localparam int STEP_SHIFT = 2;
  // ----------------------------------------
  // 2-byte float brightness code
  // ----------------------------------------
  localparam int DPT_SIGN = 15;
  localparam int DPT_EXP_MSB = 14;
  localparam int DPT_EXP_LSB = 11;
  localparam int DPT_MANT_MSB = 10;
  localparam logic [22:0] DPT_MANT_MAX = 23'h0007FF;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {logic valid; logic [15:0] raw;} word_tg_type;
  typedef struct packed {logic valid; logic up; logic [2:0] step;} dim_tg_type;
  typedef struct packed {logic valid; logic value;} bit_tg_type;
  typedef struct packed {logic adjust; logic fastInterval; logic largeStep;} loop_type;

  // clamp a lux value into a window
  function automatic logic [LUX_W-1:0] clampLux(input logic [LUX_W-1:0] v, input logic [LUX_W-1:0] lo,
                                               input logic [LUX_W-1:0] hi);
    clampLux = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// ===== core/lux_from_code.sv
// Purpose: turn a 2-byte float brightness code into integer lux
// Assumes: negative codes mean no light
// Notes: one cycle of latency, result saturates at full scale
`timescale 1ns/1ns
module lux_from_code import setpoint_pkg::*; (
  // system
  input logic clk,
  input logic srst,
  // code in
  input logic [15:0] code,
  input logic codeValid,
  // lux out
  output logic [LUX_W-1:0] lux,
  output logic luxValid
);
  logic [26:0] mag;
  logic [26:0] quot;

  // mantissa times power of two, in hundredths
  always_comb begin
    mag = 27'(code[DPT_MANT_MSB:0]) << code[DPT_EXP_MSB:DPT_EXP_LSB];
    quot = mag / 27'(PCT);
  end

  // registered result
  always_ff @(posedge clk) begin
    if (srst) begin
      lux <= LUX_ZERO;
      luxValid <= 1'b0;
    end else begin
      luxValid <= codeValid;
      if (code[DPT_SIGN]) begin
        lux <= LUX_ZERO;
      end else if (quot > 27'(LUX_SAT)) begin
        lux <= LUX_SAT;
      end else begin
        lux <= LUX_W'(quot);
      end
    end
  end
endmodule

// ===== core/code_from_lux.sv
// Purpose: turn integer lux into a 2-byte float brightness code
// Assumes: lux is never negative
// Notes: one cycle of latency, smallest exponent that fits is used
`timescale 1ns/1ns
module code_from_lux import setpoint_pkg::*; (
  // system
  input logic clk,
  input logic srst,
  // lux in
  input logic [LUX_W-1:0] lux,
  // code out
  output logic [15:0] code
);
  logic [22:0] scaled;
  logic [3:0] expo;
  logic [10:0] mant;
  logic found;

  // search the exponent
  always_comb begin
    scaled = 23'(lux) * PCT;
    expo = 4'h0;
    mant = scaled[10:0];
    found = 1'b0;
    for (int e = 0; e < 16; e++) begin
      if (!found && ((scaled >> e) <= DPT_MANT_MAX)) begin
        found = 1'b1;
        expo = 4'(e);
        mant = 11'(scaled >> e);
      end
    end
  end

  // registered code, sign always clear
  always_ff @(posedge clk) begin
    if (srst) begin
      code <= 16'h0000;
    end else begin
      code <= {1'b0, expo, mant};
    end
  end
endmodule

// ===== core/light_setpoint_manager.sv
// Purpose: brightness target keeping for a constant-light controller
// Assumes: telegram inputs are one-cycle strobes on clk
// Notes: registers over Avalon-MM, one wait cycle per access
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module light_setpoint_manager import setpoint_pkg::*; #(
  parameter int DELAY_W = 16
)(
  // system
  input logic clk,
  input logic srst,
  // avalon-mm slave
  input logic [ADDR_W-1:0] address,
  input logic read,
  input logic write,
  input logic [3:0] byteenable,
  input logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // telegrams received
  input word_tg_type targetLevelWrite,
  input dim_tg_type targetNudgeDim,
  input bit_tg_type learnCurrentLevelCmd,
  input logic targetRestoreCmd,
  input logic reportReadReq,
  // control loop side
  input logic [LUX_W-1:0] measuredLux,
  input logic controlPhase,
  // telegrams sent
  output dim_tg_type channelOneDim,
  output word_tg_type activeTargetReport,
  // loop parameters
  output logic [LUX_W-1:0] activeTarget,
  output logic [LUX_W-1:0] bandUpper,
  output logic [LUX_W-1:0] ceilingLux,
  output logic [LUX_W-1:0] darkLux,
  output loop_type loopFlags
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ackQ, wrEn, cmdDownload, cmdBusReturn;
  logic [CTRL_W-1:0] ctrlQ;
  logic [LUX_W-1:0] cfgTargetQ, cfgCeilQ, cfgDarkQ, hystQ, nudgeHiQ, nudgeLoQ;
  logic [DELAY_W-1:0] delayQ, cntQ;
  logic [31:0] rdMux;
  logic [15:0] wrMerged;
  logic userMode, extSetQ, tempQ, savedSetQ, nudgingQ, phaseQ, phaseEnd;
  logic [LUX_W-1:0] extTargetQ, savedTargetQ, cfgEff, tgtD, ceilD, darkD, bandD, activeQ, prevQ;
  logic [LUX_W-1:0] decLux, nudgeValue, errLux;
  logic writeEvent, learnAdopt, learnRestore, nudgeTg, nudgeStop, hitHi, hitLo, nudgeEnd;
  logic trig, sendNow, pendingQ;
  logic [15:0] encCode;
  logic [1:0] pol;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // one wait cycle, then answer
  assign waitrequest = (read | write) & ~ackQ;
  assign wrEn = write & ackQ;
  assign wrMerged = {byteenable[1] ? writedata[15:8] : 8'h00, byteenable[0] ? writedata[7:0] : 8'h00};
  assign cmdDownload = wrEn & (address == OFS_CMD) & byteenable[0] & writedata[CMD_DOWNLOAD];
  assign cmdBusReturn = wrEn & (address == OFS_CMD) & byteenable[0] & writedata[CMD_BUS_RETURN];

  always_ff @(posedge clk) begin
    if (srst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (read | write) & ~ackQ;
    end
  end

  // configuration writes, lux fields clamped to legal ranges
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlQ <= CTRL_RESET;
      cfgTargetQ <= TARGET_DEF;
      cfgCeilQ <= CEIL_DEF;
      cfgDarkQ <= DARK_DEF;
      hystQ <= HYST_MIN;
      nudgeHiQ <= LUX_MAX;
      nudgeLoQ <= LUX_MIN;
      delayQ <= '0;
    end else if (wrEn) begin
      case (address)
        OFS_CTRL: ctrlQ <= CTRL_W'(wrMerged);
        OFS_CFG_TARGET: cfgTargetQ <= clampLux(wrMerged, LUX_MIN, LUX_MAX);
        OFS_CFG_CEIL: cfgCeilQ <= clampLux(wrMerged, LUX_MIN, LUX_MAX);
        OFS_CFG_DARK: cfgDarkQ <= clampLux(wrMerged, LUX_ZERO, LUX_MAX);
        OFS_HYST: hystQ <= clampLux(wrMerged, HYST_MIN, HYST_MAX);
        OFS_NUDGE_HI: nudgeHiQ <= clampLux(wrMerged, LUX_MIN, LUX_MAX);
        OFS_NUDGE_LO: nudgeLoQ <= clampLux(wrMerged, LUX_MIN, LUX_MAX);
        OFS_DELAY: delayQ <= DELAY_W'(wrMerged);
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    case (address)
      OFS_CTRL: rdMux = 32'(ctrlQ);
      OFS_CFG_TARGET: rdMux = 32'(cfgTargetQ);
      OFS_CFG_CEIL: rdMux = 32'(cfgCeilQ);
      OFS_CFG_DARK: rdMux = 32'(cfgDarkQ);
      OFS_HYST: rdMux = 32'(hystQ);
      OFS_NUDGE_HI: rdMux = 32'(nudgeHiQ);
      OFS_NUDGE_LO: rdMux = 32'(nudgeLoQ);
      OFS_DELAY: rdMux = 32'(delayQ);
      OFS_ACTIVE: rdMux = 32'(activeQ);
      OFS_BAND: rdMux = 32'(bandUpper);
      OFS_CEIL_EFF: rdMux = 32'(ceilingLux);
      OFS_DARK_EFF: rdMux = 32'(darkLux);
      OFS_STATUS: rdMux = {28'h0000000, pendingQ, tempQ, nudgingQ, extSetQ};
      default: rdMux = 32'h00000000;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= 32'h00000000;
    end else if (read & ~ackQ) begin
      readdata <= rdMux;
    end
  end

  // ----------------------------------------
  // effective parameters
  // ----------------------------------------
  assign userMode = ctrlQ[CTRL_USER];
  assign pol = ctrlQ[CTRL_POL_MSB:CTRL_POL_LSB];

  // configured target snapped to the mode's grid
  always_comb begin
    if (userMode) begin
      cfgEff = cfgTargetQ;
    end else if (cfgTargetQ < STD_STEP) begin
      cfgEff = STD_LOW;
    end else if (cfgTargetQ > STD_MAX) begin
      cfgEff = STD_MAX;
    end else begin
      cfgEff = cfgTargetQ - (cfgTargetQ % STD_STEP);
    end
  end

  // ceiling, darkness, active target and band top
  assign ceilD = userMode ? cfgCeilQ : LUX_W'((19'(cfgEff) * CEIL_NUM) / CEIL_DEN);
  assign darkD = userMode ? cfgDarkQ : LUX_ZERO;
  assign tgtD = extSetQ ? extTargetQ : cfgEff;
  assign bandD = LUX_W'(23'(tgtD) + (23'(tgtD) * 23'(hystQ)) / PCT);
  assign errLux = (measuredLux > activeQ) ? measuredLux - activeQ : activeQ - measuredLux;

  always_ff @(posedge clk) begin
    if (srst) begin
      activeQ <= LUX_ZERO;
      bandUpper <= LUX_ZERO;
      ceilingLux <= LUX_ZERO;
      darkLux <= LUX_ZERO;
      loopFlags <= '0;
    end else begin
      activeQ <= tgtD;
      bandUpper <= bandD;
      ceilingLux <= ceilD;
      darkLux <= darkD;
      loopFlags.adjust <= controlPhase & ((measuredLux < activeQ) | (measuredLux > bandUpper));
      loopFlags.fastInterval <= measuredLux < darkLux;
      loopFlags.largeStep <= errLux > (ceilingLux >> STEP_SHIFT);
    end
  end
  assign activeTarget = activeQ;

  // ----------------------------------------
  // target sources
  // ----------------------------------------
  lux_from_code u_dec (
    .clk(clk),
    .srst(srst),
    .code(targetLevelWrite.raw),
    .codeValid(targetLevelWrite.valid & ctrlQ[CTRL_WRITE_EN]),
    .lux(decLux),
    .luxValid(writeEvent)
  );

  // learn polarity decode
  assign learnAdopt = learnCurrentLevelCmd.valid & ctrlQ[CTRL_LEARN_EN] &
    ((pol == POL_ONE) ? learnCurrentLevelCmd.value : (pol == POL_ZERO) ? ~learnCurrentLevelCmd.value : 1'b1);
  assign learnRestore = learnCurrentLevelCmd.valid & ctrlQ[CTRL_LEARN_EN] &
    ((pol == POL_ONE) ? ~learnCurrentLevelCmd.value : (pol == POL_ZERO) ? learnCurrentLevelCmd.value : 1'b0);

  // nudge tracking and limit stops
  assign nudgeTg = targetNudgeDim.valid & ctrlQ[CTRL_NUDGE_EN] & controlPhase;
  assign nudgeStop = nudgeTg & (targetNudgeDim.step == 3'h0) & nudgingQ;
  assign hitHi = nudgingQ & controlPhase & (measuredLux > nudgeHiQ);
  assign hitLo = nudgingQ & controlPhase & ~hitHi & (measuredLux < nudgeLoQ);
  assign nudgeEnd = nudgeStop | hitHi | hitLo;
  assign nudgeValue = hitHi ? nudgeHiQ : (hitLo ? nudgeLoQ : measuredLux);
  assign phaseEnd = phaseQ & ~controlPhase;

  always_ff @(posedge clk) begin
    if (srst) begin
      nudgingQ <= 1'b0;
      phaseQ <= 1'b0;
    end else begin
      phaseQ <= controlPhase;
      if (nudgeEnd | ~controlPhase) begin
        nudgingQ <= 1'b0;
      end else if (nudgeTg & (targetNudgeDim.step != 3'h0)) begin
        nudgingQ <= 1'b1;
      end
    end
  end

  // forward to channel one, forced stop on a limit
  always_ff @(posedge clk) begin
    if (srst) begin
      channelOneDim <= '0;
    end else begin
      channelOneDim.valid <= nudgeTg | hitHi | hitLo;
      channelOneDim.up <= targetNudgeDim.up;
      channelOneDim.step <= (hitHi | hitLo) ? 3'h0 : targetNudgeDim.step;
    end
  end

  // the active source, fixed priority for one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      extSetQ <= 1'b0;
      extTargetQ <= LUX_ZERO;
      tempQ <= 1'b0;
      savedSetQ <= 1'b0;
      savedTargetQ <= LUX_ZERO;
    end else if (writeEvent) begin
      extSetQ <= 1'b1;
      extTargetQ <= clampLux(decLux, LUX_MIN, LUX_MAX);
      tempQ <= 1'b0;
    end else if (learnAdopt) begin
      extSetQ <= 1'b1;
      extTargetQ <= measuredLux;
      tempQ <= 1'b0;
    end else if (nudgeEnd) begin
      extSetQ <= 1'b1;
      extTargetQ <= nudgeValue;
      tempQ <= ~ctrlQ[CTRL_NUDGE_PERM];
      if (~ctrlQ[CTRL_NUDGE_PERM] & ~tempQ) begin
        savedSetQ <= extSetQ;
        savedTargetQ <= extTargetQ;
      end
    end else if (targetRestoreCmd | learnRestore) begin
      extSetQ <= 1'b0;
      tempQ <= 1'b0;
    end else if (cmdDownload & ctrlQ[CTRL_OVERWRITE]) begin
      extSetQ <= 1'b0;
      tempQ <= 1'b0;
    end else if (phaseEnd & tempQ) begin
      extSetQ <= savedSetQ;
      extTargetQ <= savedTargetQ;
      tempQ <= 1'b0;
    end
  end

  // ----------------------------------------
  // target report
  // ----------------------------------------
  code_from_lux u_enc (
    .clk(clk),
    .srst(srst),
    .lux(activeQ),
    .code(encCode)
  );

  assign trig = ctrlQ[CTRL_REPORT_EN] & ctrlQ[CTRL_REPORT_ACT] &
    ((activeQ != prevQ) | cmdDownload | cmdBusReturn);
  assign sendNow = (pendingQ & (cntQ == '0) & ~trig) | (reportReadReq & ctrlQ[CTRL_REPORT_EN]);

  // delay counter for the active report
  always_ff @(posedge clk) begin
    if (srst) begin
      prevQ <= LUX_ZERO;
      pendingQ <= 1'b0;
      cntQ <= '0;
    end else begin
      prevQ <= activeQ;
      if (trig) begin
        pendingQ <= 1'b1;
        cntQ <= delayQ;
      end else if (pendingQ & (cntQ != '0)) begin
        cntQ <= cntQ - DELAY_W'(1);
      end else begin
        pendingQ <= 1'b0;
      end
    end
  end

  // report telegram
  always_ff @(posedge clk) begin
    if (srst) begin
      activeTargetReport <= '0;
    end else begin
      activeTargetReport.valid <= sendNow;
      activeTargetReport.raw <= encCode;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ceil_std_ratio: assert property (
    !userMode && !srst |=> ceilingLux == LUX_W'((19'($past(cfgEff)) * CEIL_NUM) / CEIL_DEN))
    else $error("standard ceiling not target times 1.2");
  a_dark_std_zero: assert property (!userMode |=> darkLux == LUX_ZERO)
    else $error("standard darkness threshold not zero");
  a_std_grid: assert property (
    !userMode |-> cfgEff == STD_LOW || (cfgEff % STD_STEP == 0 && cfgEff >= STD_STEP && cfgEff <= STD_MAX))
    else $error("standard target off grid");
  a_user_range: assert property (
    userMode |-> cfgEff >= LUX_MIN && cfgEff <= LUX_MAX)
    else $error("user target out of range");
  a_band_top: assert property (
    bandUpper == LUX_W'(23'(activeTarget) + (23'(activeTarget) * 23'($past(hystQ))) / PCT))
    else $error("band top not target plus hysteresis");
  a_band_quiet: assert property (
    controlPhase && measuredLux >= activeTarget && measuredLux <= bandUpper |=> !loopFlags.adjust)
    else $error("adjust requested inside band");
  a_dark_fast: assert property (measuredLux < darkLux |=> loopFlags.fastInterval)
    else $error("fast interval missing below darkness");
  a_nudge_hi_stop: assert property (
    hitHi && !writeEvent && !learnAdopt |=> channelOneDim.valid && channelOneDim.step == 3'h0
      && extTargetQ == $past(nudgeHiQ) && !nudgingQ)
    else $error("upper nudge limit not applied");
  a_nudge_lo_stop: assert property (
    hitLo && !writeEvent && !learnAdopt |=> channelOneDim.valid && extTargetQ == $past(nudgeLoQ))
    else $error("lower nudge limit not applied");
  a_learn_adopt: assert property (
    learnAdopt && !writeEvent |=> extSetQ && extTargetQ == $past(measuredLux) ##1 activeTarget == $past(extTargetQ))
    else $error("learned target not adopted");
  a_restore_cfg: assert property (
    (targetRestoreCmd || learnRestore) && !writeEvent && !learnAdopt && !nudgeEnd |=> !extSetQ ##1 activeTarget == $past(cfgEff))
    else $error("restore did not return to configured target");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered");

  c_nudge_hi: cover property (hitHi ##1 channelOneDim.valid);
  c_learn: cover property (learnAdopt);
  c_report: cover property (trig ##[1:20] activeTargetReport.valid);
  c_temp_end: cover property (phaseEnd && tempQ);
endmodule

// ===== verif/bus_sender.sv
// Purpose: far-side bus model that sends 2-byte brightness telegrams
// Assumes: lux requests fit the float code once scaled by 100
// Notes: raw field shows junk while no telegram is on the bus
`timescale 1ns/1ns
module bus_sender import setpoint_pkg::*; (
  // system
  input logic clk,
  // request from the bench
  input logic go,
  input logic [LUX_W-1:0] lux,
  // telegram out
  output word_tg_type tg
);
  // smallest exponent whose mantissa fits 11 bits
  function automatic logic [15:0] enc(input logic [LUX_W-1:0] v);
    int m;
    int e;
    m = v * 100;
    e = 0;
    while (m > 2047) begin
      m = m >> 1;
      e++;
    end
    return {1'b0, 4'(e), 11'(m)};
  endfunction
  // one-cycle telegram, inverted raw when idle
  always @(posedge clk) begin
    tg.valid <= go;
    tg.raw <= go ? enc(lux) : ~tg.raw;
  end
endmodule

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the light setpoint manager
// Assumes: one wait cycle per bus access, telegrams settle within 5 cycles
// Notes: random lux drawn from an xorshift seeded with 32'h92BB
`timescale 1ns/1ns
module tb_top;
  import setpoint_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, restore = 1'b0, repReq = 1'b0;
  logic phase = 1'b0, go = 1'b0, waitrequest;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0, readdata, q;
  logic [LUX_W-1:0] meas = 16'h0000, goLux = 16'h0000, activeTarget, bandUpper, lux;
  word_tg_type wtg, report;
  dim_tg_type nudge = '0, ch;
  bit_tg_type learn = '0;
  loop_type flags;
  logic [31:0] seed = 32'h92BB;
  int failures = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  bus_sender sender (.clk(clk), .go(go), .lux(goLux), .tg(wtg));
  light_setpoint_manager uut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .byteenable(4'h3), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .targetLevelWrite(wtg), .targetNudgeDim(nudge), .learnCurrentLevelCmd(learn),
    .targetRestoreCmd(restore), .reportReadReq(repReq), .measuredLux(meas), .controlPhase(phase),
    .channelOneDim(ch), .activeTargetReport(report), .activeTarget(activeTarget),
    .bandUpper(bandUpper), .ceilingLux(), .darkLux(), .loopFlags(flags));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] clampExp(input logic [31:0] v);
    return (v < 32'h000A) ? 32'h000A : ((v > 32'h07D0) ? 32'h07D0 : v);
  endfunction
  // float brightness code of a lux value, smallest exponent first
  function automatic logic [15:0] codeOf(input logic [15:0] v);
    int m;
    int e;
    m = int'(v) * 100;
    e = 0;
    while (m > 2047) begin
      m = m >> 1;
      e++;
    end
    return {1'b0, 4'(e), 11'(m)};
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    chk(nm, q, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, 32'h0200, "ctrl reset");
    rd(OFS_ACTIVE, 32'h0258, "target def");
    rd(OFS_CEIL_EFF, 32'h02D0, "std ceiling");
    rd(OFS_DARK_EFF, 32'h0000, "std dark");
    rd(OFS_BAND, 32'h0294, "band def");
    rd(6'h3C, 32'h0000, "unmapped");
    bus(1'b1, OFS_CTRL, 16'h032D);
    rd(OFS_DARK_EFF, 32'h00C8, "user dark");
    rd(OFS_CEIL_EFF, 32'h02D0, "user ceiling");
    bus(1'b1, OFS_HYST, 16'h0063);
    rd(OFS_HYST, 32'h0032, "hyst clamp");
    rd(OFS_BAND, 32'h0384, "band 50pct");
    $display("test registers done");
    // random target telegrams, last one fixed
    for (int i = 0; i < 7; i++) begin
      lux = (i == 6) ? 16'h0140 : 16'((xs() % 70) * 32);
      @(posedge clk) begin go <= 1'b1; goLux <= lux; end
      @(posedge clk) go <= 1'b0;
      tick(5);
      chk("write target", 32'(activeTarget), clampExp(32'(lux)));
    end
    @(posedge clk) repReq <= 1'b1;
    @(posedge clk) repReq <= 1'b0;
    @(negedge clk);
    chk("report", 32'(report), {15'h0000, 1'b1, codeOf(16'h0140)});
    $display("test target write done");
    // learn, opposite value restores, then loop flags
    @(posedge clk) begin
      phase <= 1'b1;
      meas <= 16'(100 + xs() % 1800);
    end
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk) learn <= '{1'b1, v[0]};
      @(posedge clk) learn.valid <= 1'b0;
      tick(4);
      chk("learn", 32'(activeTarget), v ? 32'(meas) : 32'h0258);
    end
    @(posedge clk) meas <= 16'h0032;
    tick(3);
    chk("flags", 32'(flags), 32'h0007);
    @(posedge clk) meas <= 16'h0271;
    tick(3);
    chk("in band", 32'(flags.adjust), 32'h0000);
    $display("test learn done");
    // nudge up past upper limit, then down past lower limit
    for (int d = 1; d >= 0; d--) begin
      @(posedge clk) begin
        meas <= 16'h03E8;
        nudge <= '{1'b1, d[0], 3'h1};
      end
      @(posedge clk) nudge.valid <= 1'b0;
      @(negedge clk);
      chk("forward", 32'(ch), {27'h0, 1'b1, d[0], 3'h1});
      @(posedge clk) meas <= d ? 16'h0834 : 16'h0005;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!(ch.valid === 1'b1 && ch.step === 3'h0) && n < 20);
      chk("auto stop", 32'(n < 20), 32'h0001);
      tick(3);
      chk("limit", 32'(activeTarget), d ? 32'h07D0 : 32'h000A);
    end
    // leaving the control phase drops the temporary nudge
    @(posedge clk) phase <= 1'b0;
    tick(4);
    chk("temp end", 32'(activeTarget), 32'h0258);
    @(posedge clk) begin go <= 1'b1; goLux <= 16'h0640; end
    @(posedge clk) go <= 1'b0;
    tick(5);
    chk("write big", 32'(activeTarget), 32'h0640);
    @(posedge clk) restore <= 1'b1;
    @(posedge clk) restore <= 1'b0;
    tick(4);
    chk("restore", 32'(activeTarget), 32'h0258);
    $display("test nudge done");
    // download with overwrite after an external write
    @(posedge clk) begin go <= 1'b1; goLux <= 16'h0640; end
    @(posedge clk) go <= 1'b0;
    tick(5);
    chk("write kept", 32'(activeTarget), 32'h0640);
    bus(1'b1, OFS_CTRL, 16'h032F);
    bus(1'b1, OFS_CMD, 16'h0001);
    tick(5);
    chk("download", 32'(activeTarget), 32'h0258);
    // bus voltage return sends the active target once
    bus(1'b1, OFS_CMD, 16'h0002);
    n = 0;
    while (report.valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("report return", 32'(report), {15'h0000, 1'b1, codeOf(16'h0258)});
    $display("test download done");
    finish_test();
  end
endmodule
